// [hw/lexp_pkg.sv]
package lexp_pkg;

  // ------------------------------------------------------------------
  // clock and link timing
  // ------------------------------------------------------------------
  localparam int CLK_NS          = 8;         // 125 MHz
  localparam int T_PER_MIN_NS    = 56400;     // 56.4 us least trigger period / phase
  localparam int T_HI_MIN_NS     = 100;       // 0.1 us least pulse high time
  localparam int T_RO_NS         = 51200;     // 51.2 us readout window
  localparam int T_RO_LVL_NS     = 112800;    // 112.8 us readout window, level mode
  localparam int T_EXPO_MIN_NS   = 56400;     // 56.4 us least programmed exposure
  localparam int T_EXPO_MAX_NS   = 32767000;  // 32767 us longest programmed exposure

  // least times round up, fixed windows are exact
  localparam int PER_MIN_CYC  = (T_PER_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int HI_MIN_CYC   = (T_HI_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int RO_CYC       = T_RO_NS / CLK_NS;
  localparam int RO_LVL_CYC   = T_RO_LVL_NS / CLK_NS;
  localparam int EXPO_MIN_CYC = (T_EXPO_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int EXPO_MAX_CYC = T_EXPO_MAX_NS / CLK_NS;

  // ------------------------------------------------------------------
  // widths and reset values
  // ------------------------------------------------------------------
  localparam int CW        = 24;  // timing counters
  localparam int EXPO_NS_W = 25;  // programmed exposure in ns
  localparam int PW        = 10;  // pixel / line data
  localparam int NUM_W     = 8;   // exposures per averaged line
  localparam int SUM_W     = PW + NUM_W;
  localparam int DIV_STEPS = SUM_W;

  typedef logic [CW-1:0] lexp_cnt_t;

  localparam lexp_cnt_t CNT_RST_SAT = '1;    // "long ago" so the first edge is legal
  localparam lexp_cnt_t CNT_RST_ZERO = '0;

  // ------------------------------------------------------------------
  // exposure modes as selected by software
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    LEXP_FREE  = 3'h0,
    LEXP_EXT   = 3'h1,
    LEXP_EDGE  = 3'h2,
    LEXP_LEVEL = 3'h3,
    LEXP_AVG   = 3'h4
  } lexp_mode_t;

  localparam lexp_mode_t MODE_RST = LEXP_FREE;

  // saturating increment for the phase counters
  function automatic lexp_cnt_t lexp_sat_inc(input lexp_cnt_t v);
    lexp_sat_inc = (v == '1) ? v : v + 1'b1;
  endfunction : lexp_sat_inc

  // larger of two counts
  function automatic lexp_cnt_t lexp_max(input lexp_cnt_t a, input lexp_cnt_t b);
    lexp_max = (a > b) ? a : b;
  endfunction : lexp_max

endpackage : lexp_pkg

// [hw/lexp_if.sv]
`timescale 1ns/100ps
`default_nettype none
interface lexp_if;
  import lexp_pkg::*;

  logic          cc1;        // trigger pulse, grabber to camera
  logic          cc2;        // encoder pulse, grabber to camera
  logic          lval;       // readout window, camera to grabber
  logic [PW-1:0] line_data;  // line value, stable while lval is high

  modport cam  (input cc1, input cc2, output lval, output line_data);
  modport grab (output cc1, output cc2, input lval, input line_data);
endinterface : lexp_if
`default_nettype wire

// [hw/lexp_cam.sv]
`timescale 1ns/100ps
`default_nettype none
module lexp_cam
  import lexp_pkg::*;
#(
  parameter int P_PER_MIN  = PER_MIN_CYC,
  parameter int P_RO       = RO_CYC,
  parameter int P_RO_LVL   = RO_LVL_CYC,
  parameter int P_EXPO_MIN = EXPO_MIN_CYC,
  parameter int P_EXPO_MAX = EXPO_MAX_CYC
) (
  // clock and reset
  input  wire logic                 mclk_i,
  input  wire logic                 srst_i,
  // link to the grabber
  lexp_if.cam                       link,
  // configuration
  input  wire logic [2:0]           mode_i,
  input  wire logic [EXPO_NS_W-1:0] expo_ns_i,
  // sensor side
  input  wire logic [PW-1:0]        pix_i,
  output logic                      expose_o,
  output logic                      exp_end_o
);

  // ------------------------------------------------------------------
  // limits at counter width
  // ------------------------------------------------------------------
  localparam lexp_cnt_t LIM_PER  = lexp_cnt_t'(P_PER_MIN);
  localparam lexp_cnt_t LIM_HI   = lexp_cnt_t'(HI_MIN_CYC);
  localparam lexp_cnt_t LIM_RO   = lexp_cnt_t'(P_RO);
  localparam lexp_cnt_t LIM_ROL  = lexp_cnt_t'(P_RO_LVL);
  localparam lexp_cnt_t LIM_EMIN = lexp_cnt_t'(P_EXPO_MIN);
  localparam lexp_cnt_t LIM_EMAX = lexp_cnt_t'(P_EXPO_MAX);
  localparam logic [NUM_W-1:0] NUM_FULL = '1;

  lexp_mode_t      mode_q;
  logic            clr;
  logic            cc1_s1, cc1_s2, cc1_q, cc2_s1, cc2_s2;
  lexp_cnt_t       hi1, lo1, per1, hi2, per2, per1_min, expo_cyc, exp_cnt, ro_cnt;
  lexp_cnt_t       next_exp_cnt, expo_raw;
  logic [EXPO_NS_W:0] ns_up;
  logic            trig1, trig2, trig2_q, lvl_rise, lvl_fall, end_ev, next_expose;
  logic            in_acc, end_acc, arm, addv, launch, dbusy, div_done, ro_go;
  logic [SUM_W-1:0] sum, sum_in, dvd;
  logic [NUM_W-1:0] num, num_in, den;
  logic [NUM_W:0]   rem, rem_sh;
  logic [4:0]       dstep;
  logic [PW-1:0]    line_data;

  // ------------------------------------------------------------------
  // mode select and programmed exposure
  // ------------------------------------------------------------------
  // a mode change flushes the period counters, exposure, averaging and readout so no mixed line escapes
  assign clr = (mode_q != lexp_mode_t'(mode_i));

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      mode_q <= MODE_RST;
    end else begin
      mode_q <= lexp_mode_t'(mode_i);
    end
  end

  // ns to cycles, rounded up, then held inside the legal range
  assign ns_up    = {1'b0, expo_ns_i} + (EXPO_NS_W+1)'(CLK_NS - 1);
  assign expo_raw = lexp_cnt_t'(ns_up / (EXPO_NS_W+1)'(CLK_NS));

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      expo_cyc <= LIM_EMIN;
    end else begin
      expo_cyc <= (expo_raw < LIM_EMIN) ? LIM_EMIN :
                  (expo_raw > LIM_EMAX) ? LIM_EMAX : expo_raw;
    end
  end

  // ------------------------------------------------------------------
  // link synchronisers and phase counters
  // ------------------------------------------------------------------
  // stage one is read by stage two only
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      {cc1_s1, cc1_s2, cc1_q, cc2_s1, cc2_s2} <= '0;
    end else begin
      {cc1_q, cc1_s2, cc1_s1} <= {cc1_s2, cc1_s1, link.cc1};
      {cc2_s2, cc2_s1}        <= {cc2_s1, link.cc2};
    end
  end

  // high, low and period counts; low and period counts reset to saturation so the first edge passes
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      {hi1, hi2}        <= {2{CNT_RST_ZERO}};
      {lo1, per1, per2} <= {3{CNT_RST_SAT}};
    end else begin
      hi1  <= cc1_s2 ? lexp_sat_inc(hi1) : '0;
      lo1  <= cc1_s2 ? '0 : lexp_sat_inc(lo1);
      per1 <= trig1 ? '0 : clr ? CNT_RST_SAT : lexp_sat_inc(per1);
      hi2  <= cc2_s2 ? lexp_sat_inc(hi2) : '0;
      per2 <= trig2 ? '0 : clr ? CNT_RST_SAT : lexp_sat_inc(per2);
    end
  end

  // trigger is taken once it has been high for the least time and the
  // period since the last taken one is legal; outside level mode a short glitch
  // never starts a truncated exposure, at the cost of a 13-cycle start latency
  assign per1_min = (mode_q == LEXP_EDGE) ? expo_cyc + LIM_PER : LIM_PER;
  assign trig1 = !clr && cc1_s2 && (hi1 == LIM_HI - 1'b1) &&
                 (per1 >= per1_min - 1'b1) &&
                 (mode_q == LEXP_EXT || mode_q == LEXP_EDGE ||
                  mode_q == LEXP_AVG);
  assign trig2 = !clr && (mode_q == LEXP_AVG) && cc2_s2 &&
                 (hi2 == LIM_HI - 1'b1) && (per2 >= LIM_PER - 1'b1);
  assign lvl_rise = !clr && (mode_q == LEXP_LEVEL) && cc1_s2 && !cc1_q &&
                    (lo1 >= LIM_PER) && !expose_o;
  assign lvl_fall = (mode_q == LEXP_LEVEL) && expose_o && !cc1_s2 && cc1_q;

  // ------------------------------------------------------------------
  // exposure sequencing
  // ------------------------------------------------------------------
  always_comb begin
    next_expose  = expose_o;
    next_exp_cnt = exp_cnt;
    end_ev       = 1'b0;
    case (mode_q)
      LEXP_FREE: begin
        if (!expose_o || exp_cnt == lexp_cnt_t'(1)) begin
          end_ev       = expose_o;
          next_expose  = 1'b1;
          next_exp_cnt = expo_cyc;
        end else begin
          next_exp_cnt = exp_cnt - 1'b1;
        end
      end
      LEXP_EXT, LEXP_AVG: begin
        if (trig1) begin
          end_ev      = expose_o;
          next_expose = 1'b1;
        end
      end
      LEXP_EDGE: begin
        if (expose_o) begin
          if (exp_cnt == lexp_cnt_t'(1)) begin
            next_expose = 1'b0;
            end_ev      = 1'b1;
          end else begin
            next_exp_cnt = exp_cnt - 1'b1;
          end
        end else if (trig1) begin
          next_expose  = 1'b1;
          next_exp_cnt = expo_cyc;
        end
      end
      LEXP_LEVEL: begin
        if (lvl_rise) begin
          next_expose = 1'b1;
        end else if (lvl_fall) begin
          next_expose = 1'b0;
          end_ev      = (hi1 >= LIM_PER);
        end
      end
      default: begin
        next_expose = 1'b0;
      end
    endcase
    if (clr) begin
      next_expose = 1'b0;
      end_ev      = 1'b0;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      {expose_o, exp_cnt, exp_end_o} <= '0;
    end else begin
      expose_o  <= next_expose;
      exp_cnt   <= next_exp_cnt;
      exp_end_o <= end_ev;  // sensor shows pix_i during this pulse
    end
  end

  // ------------------------------------------------------------------
  // encoder-period averaging
  // ------------------------------------------------------------------
  // the line is closed one cycle after the encoder edge so a sample still
  // in flight from the exposure that just ended lands in the old line
  assign addv   = (mode_q == LEXP_AVG) && exp_end_o && end_acc && (num != NUM_FULL);
  assign sum_in = addv ? sum + SUM_W'(pix_i) : sum;
  assign num_in = addv ? num + 1'b1 : num;
  assign launch = trig2_q && (num_in != '0);

  always_ff @(posedge mclk_i) begin
    if (srst_i || clr) begin
      {arm, in_acc, end_acc, trig2_q} <= '0;
      {sum, num}                      <= '0;
    end else begin
      trig2_q <= trig2;
      arm     <= arm | trig2;
      if (trig1) begin
        in_acc <= arm | trig2;
      end else if (trig2) begin
        in_acc <= 1'b0;  // running exposure began before the encoder edge
      end
      if (end_ev) begin
        end_acc <= in_acc;
      end
      sum <= trig2_q ? '0 : sum_in;  // a new line starts empty
      num <= trig2_q ? '0 : num_in;
    end
  end

  // restoring divider, one quotient bit per cycle
  assign rem_sh = {rem[NUM_W-1:0], dvd[SUM_W-1]};

  always_ff @(posedge mclk_i) begin
    if (srst_i || clr) begin
      {dvd, den, rem, dstep, dbusy, div_done} <= '0;
    end else begin
      div_done <= dbusy && (dstep == 5'h01);
      if (launch) begin
        dvd   <= sum_in;
        den   <= num_in;
        rem   <= '0;
        dstep <= 5'(DIV_STEPS);
        dbusy <= 1'b1;
      end else if (dbusy) begin
        rem <= (rem_sh >= {1'b0, den}) ? rem_sh - {1'b0, den} : rem_sh;
        dvd <= {dvd[SUM_W-2:0], (rem_sh >= {1'b0, den})};
        dstep <= dstep - 1'b1;
        dbusy <= (dstep != 5'h01);
      end
    end
  end

  // ------------------------------------------------------------------
  // readout window
  // ------------------------------------------------------------------
  assign ro_go = (mode_q == LEXP_AVG) ? div_done : exp_end_o;

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      ro_cnt    <= CNT_RST_ZERO;
      line_data <= '0;
    end else if (clr) begin
      ro_cnt <= CNT_RST_ZERO;  // last line stays on the link, data moves only at a window start
    end else if (ro_go) begin
      ro_cnt    <= (mode_q == LEXP_LEVEL) ? LIM_ROL : LIM_RO;
      line_data <= (mode_q == LEXP_AVG) ? dvd[PW-1:0] : pix_i;
    end else if (ro_cnt != '0) begin
      ro_cnt <= ro_cnt - 1'b1;
    end
  end

  assign link.lval      = (ro_cnt != '0);
  assign link.line_data = line_data;

endmodule : lexp_cam
`default_nettype wire

// [hw/lexp_grab.sv]
`timescale 1ns/100ps
`default_nettype none
module lexp_grab
  import lexp_pkg::*;
#(
  parameter int P_PER_MIN = PER_MIN_CYC
) (
  // clock and reset
  input  wire logic          mclk_i,
  input  wire logic          srst_i,
  // link to the camera
  lexp_if.grab               link,
  // pulse programme, in clock cycles
  input  wire logic          run_i,
  input  wire logic [2:0]    mode_i,
  input  wire lexp_cnt_t     expo_cyc_i,
  input  wire lexp_cnt_t     cc1_per_i,
  input  wire lexp_cnt_t     cc1_high_i,
  input  wire lexp_cnt_t     cc2_per_i,
  input  wire lexp_cnt_t     cc2_high_i,
  // received lines
  output logic [PW-1:0]      line_o,
  output logic               line_stb_o
);

  // ------------------------------------------------------------------
  // pulse shape, forced inside the camera's limits
  // ------------------------------------------------------------------
  localparam lexp_cnt_t LIM_PER = lexp_cnt_t'(P_PER_MIN);
  localparam lexp_cnt_t LIM_HI  = lexp_cnt_t'(HI_MIN_CYC);

  lexp_mode_t mode;
  lexp_cnt_t  high [2];
  lexp_cnt_t  per  [2];
  lexp_cnt_t  cnt  [2];
  lexp_cnt_t  next_cnt [2];
  logic       cc [2];
  logic       lval_q;

  assign mode = lexp_mode_t'(mode_i);

  // settings below a limit are raised rather than sent as illegal pulses
  always_comb begin
    high[0] = lexp_max(cc1_high_i, (mode == LEXP_LEVEL) ? LIM_PER : LIM_HI);
    per[0]  = lexp_max(cc1_per_i, (mode == LEXP_EDGE) ? expo_cyc_i + LIM_PER : LIM_PER);
    per[0]  = lexp_max(per[0], high[0] + ((mode == LEXP_LEVEL) ? LIM_PER : LIM_HI));
    high[1] = lexp_max(cc2_high_i, LIM_HI);
    per[1]  = lexp_max(lexp_max(cc2_per_i, LIM_PER), high[1] + LIM_HI);
  end

  // ------------------------------------------------------------------
  // pulse generators; the encoder runs only in average mode
  // ------------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      next_cnt[i] = (cnt[i] >= per[i] - 1'b1) ? '0 : cnt[i] + 1'b1;
    end
  end

  always_ff @(posedge mclk_i) begin
    for (int i = 0; i < 2; i++) begin
      if (srst_i) begin
        cnt[i] <= CNT_RST_ZERO;
        cc[i]  <= 1'b0;
      end else if ((!run_i || (i == 1 && mode != LEXP_AVG)) &&
                   !(cc[i] && next_cnt[i] != '0 && next_cnt[i] < high[i])) begin
        // a pulse in flight ends at full width before parking
        cnt[i] <= per[i] - 1'b1;  // next run opens with a full high phase
        cc[i]  <= 1'b0;
      end else begin
        cnt[i] <= next_cnt[i];
        cc[i]  <= (next_cnt[i] < high[i]);
      end
    end
  end

  assign link.cc1 = cc[0];
  assign link.cc2 = cc[1];

  // ------------------------------------------------------------------
  // line capture at the opening of each readout window
  // ------------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      lval_q     <= 1'b0;
      line_o     <= '0;
      line_stb_o <= 1'b0;
    end else begin
      lval_q     <= link.lval;
      line_stb_o <= link.lval && !lval_q;
      if (link.lval && !lval_q) begin
        line_o <= link.line_data;
      end
    end
  end

endmodule : lexp_grab
`default_nettype wire

// [bench/lexp_monitor.sv]
`timescale 1ns/100ps
`default_nettype none
module lexp_monitor
  import lexp_pkg::*;
#(
  parameter int P_PER_MIN = PER_MIN_CYC,
  parameter int P_RO      = RO_CYC,
  parameter int P_RO_LVL  = RO_LVL_CYC
) (
  // clock and reset
  input  wire logic          mclk_i,
  input  wire logic          srst_i,
  // link signals, observed only
  input  wire logic          cc1,
  input  wire logic          cc2,
  input  wire logic          lval,
  input  wire logic [PW-1:0] line_data
);
  // ----------
  // run and spacing counters
  // ----------
  lexp_cnt_t lv_run;
  lexp_cnt_t lv_gap;
  lexp_cnt_t c1_run;
  lexp_cnt_t c1_gap;
  lexp_cnt_t c2_run;
  lexp_cnt_t c2_gap;

  function automatic lexp_cnt_t bump(input lexp_cnt_t v);
    bump = (v == '1) ? v : v + 1'b1;
  endfunction : bump

  // gaps start saturated so the first edge after reset is always legal
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      lv_run <= '0;
      lv_gap <= '1;
    end else begin
      lv_run <= lval ? bump(lv_run) : '0;
      lv_gap <= $rose(lval) ? '0 : bump(lv_gap);
    end
  end

  // trigger pulse high time and rise spacing
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      c1_run <= '0;
      c1_gap <= '1;
    end else begin
      c1_run <= cc1 ? bump(c1_run) : '0;
      c1_gap <= $rose(cc1) ? '0 : bump(c1_gap);
    end
  end

  // encoder pulse high time and rise spacing
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      c2_run <= '0;
      c2_gap <= '1;
    end else begin
      c2_run <= cc2 ? bump(c2_run) : '0;
      c2_gap <= $rose(cc2) ? '0 : bump(c2_gap);
    end
  end

  // ----------
  // assertions
  // ----------
  default clocking @(posedge mclk_i);
  endclocking
  default disable iff (srst_i);

  a_window_len: assert property (
    $fell(lval) |-> (lv_run == P_RO || lv_run == P_RO_LVL))
    else $error("readout window has the wrong length");
  a_window_gap: assert property (
    $rose(lval) |-> lv_gap >= P_PER_MIN - 1)
    else $error("readout windows start too close together");
  a_data_hold: assert property (
    $past(lval) && lval |-> $stable(line_data))
    else $error("line data moved inside the window");
  a_data_moves: assert property (
    $changed(line_data) |-> $rose(lval))
    else $error("line data changed outside a window start");
  a_trig_high: assert property (
    $fell(cc1) |-> c1_run >= HI_MIN_CYC)
    else $error("trigger pulse too short");
  a_trig_period: assert property (
    $rose(cc1) |-> c1_gap >= P_PER_MIN - 1)
    else $error("trigger period too short");
  a_enc_high: assert property (
    $fell(cc2) |-> c2_run >= HI_MIN_CYC)
    else $error("encoder pulse too short");
  a_enc_period: assert property (
    $rose(cc2) |-> c2_gap >= P_PER_MIN - 1)
    else $error("encoder period too short");
endmodule : lexp_monitor
`default_nettype wire

// [bench/line_exposure_trigger_timing_bench.sv]
`timescale 1ns/100ps
`default_nettype none
module line_exposure_trigger_timing_bench
  import lexp_pkg::*;
;
  // shortened counts keep each line to tens of cycles
  localparam int PM = 64;
  localparam int RO = 40;
  localparam int RL = 90;
  localparam int PE = 64;

  logic                 mclk_i;
  logic                 srst_i = 1'b1;
  logic                 run_i = 1'b0;
  logic [2:0]           mode = 3'h0;
  logic [EXPO_NS_W-1:0] expo_ns = 25'h320;
  logic [PW-1:0]        pix = 10'h155;
  lexp_cnt_t            expo_cyc = 24'h46;
  lexp_cnt_t            c1_per = 24'h64;
  lexp_cnt_t            c1_hi = 24'h14;
  lexp_cnt_t            c2_per = 24'h15e;
  lexp_cnt_t            c2_hi = 24'h14;
  logic                 expose_o;
  logic                 exp_end_o;
  logic                 expose2;
  logic                 end2;
  logic [PW-1:0]        line_o;
  logic                 line_stb_o;
  int                   err_total = 0;
  int                   num_checks = 0;
  int                   cyc = 0;
  int                   lows = 0;
  int                   hi2 = 0;
  int                   ends2 = 0;
  int                   t0 = 0;
  int                   stbs = 0;

  // ----------
  // two ends joined, plus a camera fed by a faulty driver
  // ----------
  lexp_if if1 ();
  lexp_if if2 ();

  lexp_cam #(.P_PER_MIN(PM), .P_RO(RO), .P_RO_LVL(RL), .P_EXPO_MIN(PE), .P_EXPO_MAX(2000))
    lexp_cam_i (.mclk_i(mclk_i), .srst_i(srst_i), .link(if1.cam), .mode_i(mode),
      .expo_ns_i(expo_ns), .pix_i(pix), .expose_o(expose_o), .exp_end_o(exp_end_o));
  lexp_cam #(.P_PER_MIN(PM), .P_RO(RO), .P_RO_LVL(RL), .P_EXPO_MIN(PE), .P_EXPO_MAX(2000))
    lexp_cam2_i (.mclk_i(mclk_i), .srst_i(srst_i), .link(if2.cam), .mode_i(3'h1),
      .expo_ns_i(expo_ns), .pix_i(pix), .expose_o(expose2), .exp_end_o(end2));
  lexp_grab #(.P_PER_MIN(PM)) lexp_grab_i (.mclk_i(mclk_i), .srst_i(srst_i),
    .link(if1.grab), .run_i(run_i), .mode_i(mode), .expo_cyc_i(expo_cyc),
    .cc1_per_i(c1_per), .cc1_high_i(c1_hi), .cc2_per_i(c2_per), .cc2_high_i(c2_hi),
    .line_o(line_o), .line_stb_o(line_stb_o));
  lexp_monitor #(.P_PER_MIN(PM), .P_RO(RO), .P_RO_LVL(RL)) lexp_monitor_i (
    .mclk_i(mclk_i), .srst_i(srst_i), .cc1(if1.cc1), .cc2(if1.cc2),
    .lval(if1.lval), .line_data(if1.line_data));

  initial begin
    mclk_i = 1'b0;
    forever #4 mclk_i = ~mclk_i;
  end

  // ----------
  // shared tasks
  // ----------
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input string what, input lexp_cnt_t seen, input lexp_cnt_t exp);
    num_checks++;
    if (seen !== exp) begin
      $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
      err_total++;
    end
  endtask : chk

  // inputs move 1 ns after the edge, outputs are read there too
  task automatic tick(input int k);
    repeat (k) begin
      @(posedge mclk_i);
      #1;
      cyc++;
      lows += (expose_o !== 1'b1);
      hi2 += (expose2 === 1'b1);
      ends2 += (end2 === 1'b1);
      stbs += (line_stb_o === 1'b1);
    end
  endtask : tick

  function automatic logic sel(input int w);
    case (w)
      0: sel = expose_o;
      1: sel = exp_end_o;
      default: sel = if1.lval;
    endcase
  endfunction : sel

  task automatic await(input int w, input logic v);
    for (int k = 0; k < 3000 && sel(w) !== v; k++) begin
      tick(1);
    end
    if (sel(w) !== v) begin
      $display("[FAIL] wait on signal %0d ran out", w);
      err_total++;
      wrap_up();
    end
  endtask : await

  task automatic hold(input int w, output int k);
    k = 0;
    while (sel(w) === 1'b1 && k < 20000) begin
      tick(1);
      k++;
    end
    if (k >= 20000) begin
      $display("[FAIL] hold on signal %0d ran out", w);
      err_total++;
      wrap_up();
    end
  endtask : hold

  task automatic end_gap(output int k);
    int s;
    await(1, 1'b1);
    s = cyc;
    tick(1);
    await(1, 1'b1);
    k = cyc - s;
  endtask : end_gap

  task automatic lv_meas(output int k);
    await(2, 1'b1);
    t0 = cyc;
    hold(2, k);
    chk("line data", if1.line_data, pix);
  endtask : lv_meas

  // idle mode in between flushes the camera, so no mixed exposure
  task automatic set_mode(input logic [2:0] m, input int p1, h1, p2, e);
    run_i = 1'b0;
    mode = 3'h5;
    c1_per = lexp_cnt_t'(p1);
    c1_hi = lexp_cnt_t'(h1);
    c2_per = lexp_cnt_t'(p2);
    expo_cyc = lexp_cnt_t'(e);
    expo_ns = EXPO_NS_W'(e * CLK_NS);
    tick(80);
    mode = m;
    run_i = 1'b1;
  endtask : set_mode

  task automatic pulse(input logic enc, input int h, input int l);
    {if2.cc2, if2.cc1} = enc ? 2'b10 : 2'b01;
    tick(h);
    {if2.cc2, if2.cc1} = 2'b00;
    tick(l);
  endtask : pulse

  // ----------
  // scenarios
  // ----------
  task automatic t_refuse();
    pulse(1'b0, 5, 60);
    chk("short pulse exposure", hi2, 0);
    pulse(1'b1, 20, 60);
    chk("encoder in trigger mode", hi2, 0);
    pulse(1'b0, 20, 10);
    pulse(1'b0, 20, 60);
    chk("early pulse end", ends2, 0);
    chk("exposure started", hi2 > 0, 1);
    pulse(1'b0, 20, 60);
    chk("legal pulse end", ends2, 1);
    $display("test refusals done");
  endtask : t_refuse

  task automatic t_free();
    int k;
    end_gap(k);
    end_gap(k);
    chk("free period", k, 800 / CLK_NS);
    lv_meas(k);
    chk("free window", k, RO);
    set_mode(3'h0, 0, 0, 0, 1);
    end_gap(k);
    chk("clamped period", k, PE);
    lv_meas(k);
    $display("test free run done");
  endtask : t_free

  task automatic t_ext();
    int k;
    pix = 10'h0c3;
    set_mode(3'h1, 100, 20, 0, 70);
    end_gap(k);
    lows = 0;
    end_gap(k);
    chk("trigger period", k, 100);
    chk("unexposed cycles", lows, 0);
    lv_meas(k);
    chk("trigger window", k, RO);
    $display("test external trigger done");
  endtask : t_ext

  task automatic t_edge();
    int k;
    int s;
    set_mode(3'h2, 200, 20, 0, 70);
    await(0, 1'b1);
    s = cyc;
    hold(0, k);
    await(0, 1'b1);
    chk("edge period", cyc - s, 200);
    hold(0, k);
    chk("edge exposure", k, 70);
    lv_meas(k);
    $display("test edge done");
  endtask : t_edge

  task automatic t_level();
    int k;
    set_mode(3'h3, 200, 100, 0, 70);
    await(0, 1'b1);
    hold(0, k);
    chk("level exposure", k, 100);
    lv_meas(k);
    chk("level window", k, RL);
    $display("test level done");
  endtask : t_level

  task automatic t_avg();
    int k;
    int s;
    pix = 10'h2aa;
    set_mode(3'h4, 70, 20, 350, 70);
    lv_meas(k);
    s = t0;
    lows = 0;
    stbs = 0;
    lv_meas(k);
    chk("line strobes", stbs, 1);
    chk("encoder line", t0 - s, 350);
    chk("average window", k, RO);
    chk("unexposed cycles", lows, 0);
    chk("grabber line", line_o, pix);
    $display("test averaging done");
  endtask : t_avg

  initial begin
    {if2.cc2, if2.cc1} = 2'b00;
    tick(4);
    srst_i = 1'b0;
    t_refuse();
    t_free();
    t_ext();
    t_edge();
    t_level();
    t_avg();
    wrap_up();
  end
endmodule : line_exposure_trigger_timing_bench
`default_nettype wire
